// ---- hw/siosp_pkg.sv ----
/*
 Shared constants and types of the separate-I/O two-word burst memory port.
 Assumes one system clock clk at 40 MHz; the memory's K and K-bar rising edges are modelled
 as the first and second phase of a two-cycle beat of clk (phase 0 = K, phase 1 = K-bar).
*/
package siosp_pkg;
  // ------------------------------------------------------------
  // Widths and timing
  // ------------------------------------------------------------
  localparam int SIOSP_WIDE_DATA_W = 36;
  localparam int SIOSP_NARROW_DATA_W = 18;
  localparam int SIOSP_WIDE_ADDR_W = 19;
  localparam int SIOSP_NARROW_ADDR_W = 20;
  localparam int SIOSP_LANE_W = 9;
  localparam int SIOSP_BURST_LEN = 2;
  localparam int SIOSP_READ_LAT_PLL = 2;
  localparam int SIOSP_READ_LAT_BYPASS = 1;
  localparam int SIOSP_CLK_MHZ = 40;
  localparam int SIOSP_BYPASS_MAX_MHZ = 167;
  localparam logic SIOSP_PHASE_RESET = 1'b0;
  localparam logic SIOSP_DIR_READ = 1'b1;
  localparam logic SIOSP_DIR_WRITE = 1'b0;

  typedef enum logic [1:0] {SIOSP_IDLE, SIOSP_WORD1, SIOSP_WORD2} siosp_host_state_type;
endpackage : siosp_pkg

// ---- hw/siosp_if.sv ----
/*
 Interface joining the memory controller end and the memory end of the port.
 Assumes both ends share clk; the two clock phases stand for the K and K-bar rising edges.
*/
interface siosp_if #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 20
) (
  input wire logic clk
);
  localparam int LANES = DATA_W / 9;
  logic k_phase;
  logic out_phase;
  logic load_strobe_n;
  logic read_not_write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [LANES-1:0] byte_lane_mask_n;
  logic [DATA_W-1:0] rdata;
  logic rdata_valid;
  logic pll_bypass_n;
  logic single_clock;

  modport ctrl (
    input clk, rdata, rdata_valid,
    output k_phase, out_phase, load_strobe_n, read_not_write, addr, wdata, byte_lane_mask_n,
    output pll_bypass_n, single_clock
  );
  modport mem (
    input clk, k_phase, out_phase, load_strobe_n, read_not_write, addr, wdata,
    input byte_lane_mask_n, pll_bypass_n, single_clock,
    output rdata, rdata_valid
  );
endinterface : siosp_if

// ---- hw/siosp_mem.sv ----
/*
 Memory end of the separate-I/O port: two-word burst array with byte-lane masked writes.
 Assumes the controller end drives k_phase as a clean alternation, one command per beat.
*/
module siosp_mem
  import siosp_pkg::*;
#(
  parameter int DATA_W = SIOSP_NARROW_DATA_W,
  parameter int ADDR_W = SIOSP_NARROW_ADDR_W,
  parameter int DEPTH_W = 8
) (
  input wire logic rst,
  siosp_if.mem port
);
  localparam int LANES = DATA_W / SIOSP_LANE_W;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr_active;
    logic [DEPTH_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_word0;
    logic [LANES-1:0] wr_mask0_n;
    logic rd_pend;
    logic rd_pend2;
    logic [DEPTH_W-1:0] rd_addr;
    logic rd_second;
    logic [DATA_W-1:0] rd_hold;
    logic [DATA_W-1:0] rdata;
    logic rdata_valid;
  } siosp_mem_state_type;

  siosp_mem_state_type state_reg;
  siosp_mem_state_type state_next;

  logic [DATA_W-1:0] array_lo [0:(1<<DEPTH_W)-1];
  logic [DATA_W-1:0] array_hi [0:(1<<DEPTH_W)-1];

  logic load_k;
  logic launch_edge;
  logic launch_go;
  logic [DEPTH_W-1:0] sel_addr;

  assign load_k = !port.load_strobe_n && (port.k_phase == SIOSP_PHASE_RESET);
  assign sel_addr = port.addr[DEPTH_W-1:0];
  // Read data leaves on output clock phase, or on input phase in single clock mode.
  assign launch_edge = port.single_clock ? port.k_phase : port.out_phase;

  // ------------------------------------------------------------
  // Array writes
  // ------------------------------------------------------------
  always_ff @(posedge port.clk) begin
    if (state_reg.wr_active && port.k_phase) begin
      for (int i = 0; i < LANES; i++) begin
        if (!state_reg.wr_mask0_n[i]) begin
          array_lo[state_reg.wr_addr][i*SIOSP_LANE_W +: SIOSP_LANE_W] <=
            state_reg.wr_word0[i*SIOSP_LANE_W +: SIOSP_LANE_W];
        end
        if (!port.byte_lane_mask_n[i]) begin
          array_hi[state_reg.wr_addr][i*SIOSP_LANE_W +: SIOSP_LANE_W] <=
            port.wdata[i*SIOSP_LANE_W +: SIOSP_LANE_W];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rdata_valid = 1'b0;
    if (state_reg.wr_active && port.k_phase) begin
      state_next.wr_active = 1'b0;
    end
    if (load_k) begin
      if (port.read_not_write == SIOSP_DIR_WRITE) begin
        state_next.wr_active = 1'b1;
        state_next.wr_addr = sel_addr;
        state_next.wr_word0 = port.wdata;
        state_next.wr_mask0_n = port.byte_lane_mask_n;
      end else begin
        state_next.rd_addr = sel_addr;
        if (port.pll_bypass_n) begin
          state_next.rd_pend2 = 1'b1;
        end else begin
          state_next.rd_pend = 1'b1;
        end
      end
    end
    if (state_reg.rd_pend2 && port.k_phase) begin
      state_next.rd_pend2 = 1'b0;
      state_next.rd_pend = 1'b1;
    end
    launch_go = state_reg.rd_pend && launch_edge;
    // Both words are taken at launch, so a later write cannot reach the second word.
    if (state_reg.rd_second) begin
      state_next.rdata = state_reg.rd_hold;
      state_next.rdata_valid = 1'b1;
      state_next.rd_second = 1'b0;
    end else if (launch_go) begin
      state_next.rdata = array_lo[state_reg.rd_addr];
      state_next.rd_hold = array_hi[state_reg.rd_addr];
      state_next.rdata_valid = 1'b1;
      state_next.rd_second = 1'b1;
      state_next.rd_pend = 1'b0;
    end
  end

  always_ff @(posedge port.clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign port.rdata = state_reg.rdata;
  assign port.rdata_valid = state_reg.rdata_valid;
endmodule : siosp_mem

// ---- hw/siosp_ctrl.sv ----
/*
 Controller end of the separate-I/O port: issues one read or write burst of two words.
 Assumes the user holds cmd_valid until cmd_ready and supplies both write words at once.
*/
module siosp_ctrl
  import siosp_pkg::*;
#(
  parameter int DATA_W = SIOSP_NARROW_DATA_W,
  parameter int ADDR_W = SIOSP_NARROW_ADDR_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [2*DATA_W-1:0] cmd_wdata,
  input wire logic [2*(DATA_W/SIOSP_LANE_W)-1:0] cmd_mask_n,
  input wire logic bypass_pll,
  input wire logic single_clock,
  output logic cmd_ready,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  siosp_if.ctrl port
);
  localparam int LANES = DATA_W / SIOSP_LANE_W;

  typedef struct packed {
    siosp_host_state_type fsm;
    logic phase;
    logic load_n;
    logic rnw;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0] mask_n;
    logic [DATA_W-1:0] word2;
    logic [LANES-1:0] mask2_n;
    logic ready;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
  } siosp_ctrl_state_type;

  siosp_ctrl_state_type state_reg;
  siosp_ctrl_state_type state_next;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.phase = !state_reg.phase;
    state_next.ready = 1'b0;
    state_next.rd_valid = port.rdata_valid;
    state_next.rd_data = port.rdata;
    unique case (state_reg.fsm)
      SIOSP_IDLE: begin
        state_next.load_n = 1'b1;
        state_next.mask_n = '1;
        if (cmd_valid && state_reg.phase && !state_reg.ready) begin
          state_next.fsm = SIOSP_WORD1;
          state_next.load_n = 1'b0;
          state_next.rnw = cmd_read;
          state_next.addr = cmd_addr;
          state_next.wdata = cmd_wdata[DATA_W-1:0];
          state_next.mask_n = cmd_read ? '1 : cmd_mask_n[LANES-1:0];
          state_next.word2 = cmd_wdata[2*DATA_W-1:DATA_W];
          state_next.mask2_n = cmd_mask_n[2*LANES-1:LANES];
          state_next.ready = 1'b1;
        end
      end
      SIOSP_WORD1: begin
        state_next.fsm = SIOSP_IDLE;
        state_next.load_n = 1'b1;
        state_next.wdata = state_reg.word2;
        state_next.mask_n = state_reg.rnw ? '1 : state_reg.mask2_n;
      end
      SIOSP_WORD2: begin
        state_next.fsm = SIOSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.load_n <= 1'b1;
      state_reg.mask_n <= '1;
      state_reg.fsm <= SIOSP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign port.k_phase = state_reg.phase;
  assign port.out_phase = state_reg.phase;
  assign port.load_strobe_n = state_reg.load_n;
  assign port.read_not_write = state_reg.rnw;
  assign port.addr = state_reg.addr;
  assign port.wdata = state_reg.wdata;
  assign port.byte_lane_mask_n = state_reg.mask_n;
  assign port.pll_bypass_n = !bypass_pll;
  assign port.single_clock = single_clock;
  assign cmd_ready = state_reg.ready;
  assign rd_data = state_reg.rd_data;
  assign rd_valid = state_reg.rd_valid;
endmodule : siosp_ctrl

// ---- sim/siosp_checker.sv ----
/*
 Checker of the port between the controller end and the memory end.
 Assumes the testbench connects it by name to the interface signals and to rst.
*/
module siosp_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic k_phase,
  input wire logic out_phase,
  input wire logic load_strobe_n,
  input wire logic read_not_write,
  input wire logic rdata_valid,
  input wire logic pll_bypass_n
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic rd_load;
  assign rd_load = !load_strobe_n && read_not_write;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_load_on_k: assert property (!load_strobe_n |-> !k_phase)
    else $error("load outside K phase");
  a_load_single: assert property (!load_strobe_n |=> load_strobe_n)
    else $error("load held longer than one cycle");
  a_out_phase: assert property (out_phase == k_phase)
    else $error("output phase off input phase");
  a_burst_two: assert property ($rose(rdata_valid) |=> rdata_valid ##1 !rdata_valid)
    else $error("read burst not two words");
  a_lat_bypass: assert property (rd_load && !pll_bypass_n |-> ##[2:3] $rose(rdata_valid))
    else $error("bypass read latency wrong");
  a_lat_pll: assert property (rd_load && pll_bypass_n |-> ##[4:5] $rose(rdata_valid))
    else $error("read latency wrong");
  a_read_cause: assert property ($rose(rdata_valid) |-> $past(rd_load, 2) ||
    $past(rd_load, 3) || $past(rd_load, 4) || $past(rd_load, 5))
    else $error("read data without a read load");
  a_reset_quiet: assert property ($fell(rst) |-> load_strobe_n && !rdata_valid)
    else $error("port busy after reset");
  c_write: cover property (!load_strobe_n && !read_not_write);
  c_read_bypass: cover property (rd_load && !pll_bypass_n);
  c_read_pll: cover property (rd_load && pll_bypass_n);
endmodule : siosp_checker

// ---- sim/testbench.sv ----
/*
 Testbench: controller and memory ends joined, writes and masked writes read back.
 Assumes the design files of hw/ are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [19:0] cmd_addr = 20'h00000;
  logic [35:0] cmd_wdata = 36'h000000000;
  logic [3:0] cmd_mask_n = 4'hF;
  logic bypass_pll = 1'b0;
  logic single_clock = 1'b0;
  logic cmd_ready;
  logic [17:0] rd_data;
  logic rd_valid;
  logic [17:0] model [0:255][0:1];
  logic [17:0] exp_q [$];
  logic [31:0] seed = 32'h4B3098C7;
  logic [63:0] wide;
  int n_mismatch = 0;
  int compares = 0;
  always #12.5 clk = ~clk;
  siosp_if #(.DATA_W(18), .ADDR_W(20)) siosp_if_i (.clk(clk));
  siosp_ctrl siosp_ctrl_i (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_mask_n(cmd_mask_n),
    .bypass_pll(bypass_pll), .single_clock(single_clock), .cmd_ready(cmd_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .port(siosp_if_i.ctrl));
  siosp_mem siosp_mem_i (.rst(rst), .port(siosp_if_i.mem));
  siosp_checker siosp_checker_i (.clk(clk), .rst(rst), .k_phase(siosp_if_i.k_phase),
    .out_phase(siosp_if_i.out_phase), .load_strobe_n(siosp_if_i.load_strobe_n),
    .read_not_write(siosp_if_i.read_not_write), .rdata_valid(siosp_if_i.rdata_valid),
    .pll_bypass_n(siosp_if_i.pll_bypass_n));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input logic [17:0] seen, input logic [17:0] want);
    compares++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %0t read word %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic results();
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic fail(input string msg);
    n_mismatch++;
    $display("BAD %0t %s", $time, msg);
    results();
  endtask : fail
  task automatic drain();
    for (int i = 0; i < 30 && exp_q.size() != 0; i++) @(posedge clk);
    if (exp_q.size() != 0) fail("read data missing");
  endtask : drain
  task automatic issue(input logic rd, input logic [19:0] a, input logic [35:0] w,
                       input logic [3:0] m);
    int i;
    if (rd) drain();
    @(posedge clk);
    #2;
    cmd_read = rd;
    cmd_addr = a;
    cmd_wdata = w;
    cmd_mask_n = m;
    cmd_valid = 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      #2;
      if (cmd_ready === 1'b1) break;
    end
    if (i == 8) fail("no command acceptance");
    cmd_valid = 1'b0;
    if (rd) begin
      exp_q.push_back(model[a[7:0]][0]);
      exp_q.push_back(model[a[7:0]][1]);
    end else begin
      for (i = 0; i < 4; i++) begin
        if (!m[i]) model[a[7:0]][i / 2][9 * (i % 2) +: 9] = w[9 * i +: 9];
      end
    end
  endtask : issue
  // ----------------------------------------
  // Result monitor and main sequence
  // ----------------------------------------
  always @(posedge clk) begin
    #1;
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) fail("read data without a read");
      else check(rd_data, exp_q.pop_front());
    end
  end
  initial begin
    logic [19:0] a;
    repeat (8) @(posedge clk);
    #2;
    rst = 1'b0;
    for (int k = 0; k < 16; k++) begin
      drain();
      @(posedge clk);
      #2;
      bypass_pll = k[0];
      single_clock = k[1];
      wide = {rnd(), rnd()};
      a = wide[19:0];
      issue(1'b0, a, wide[63:28], 4'h0);
      issue(1'b1, a, 36'h000000000, 4'hF);
      wide = {rnd(), rnd()};
      issue(1'b0, a, wide[35:0], k[3:0]);
      issue(1'b1, a, 36'h000000000, 4'hF);
    end
    drain();
    results();
  end
endmodule : testbench
